// ### bench/sbp_link_datapath_checker.sv
`timescale 1ns/1ps
module sbp_link_datapath_checker
	import sbp_pkg::*;
(
	input wire logic			aclk,
	input wire logic			aresetn,
	input wire logic			link_iface_gen_select,
	input wire logic			power_down_pin,
	input wire logic			port0_force_legacy,
	input wire logic			port1_force_legacy,
	input wire logic			port2_force_legacy,
	input wire logic [NUM_PORTS-1:0]	port_connected,
	input wire logic [NUM_PORTS-1:0]	port_active,
	input wire logic [NUM_PORTS-1:0]	peer_bilingual,
	input wire logic			link_clk_out,
	input wire logic [2:0]			link_tx_speed,
	input wire logic			link_tx_ready,
	input wire logic [NUM_PORTS-1:0]	cable_tx_en,
	input wire logic [NUM_PORTS-1:0]	port_bilingual,
	input wire logic			boss_arb_enable,
	input wire logic			pll_running
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	////////////////////////////////////////////////////////////////
	// cycles between link clock edges; the nco jitters by one cycle
	logic		clk_q;
	logic		seen;
	logic [3:0]	gap;
	always_ff @(posedge aclk) begin
		clk_q <= link_clk_out;
		if (!aresetn || !pll_running) begin
			gap <= 4'h0;
			seen <= 1'b0;
		end else if (link_clk_out != clk_q) begin
			gap <= 4'h1;
			seen <= 1'b1;
		end else if (gap != 4'hf)
			gap <= gap + 4'h1;
	end

	////////////////////////////////////////////////////////////////
	boss_follow_a: assert property (pll_running |-> boss_arb_enable == link_iface_gen_select)
		else $error("boss arbitration does not follow strap");
	pll_halt_a: assert property (power_down_pin [*5] |-> !pll_running)
		else $error("pll still running in power down");
	clk_halt_a: assert property (!pll_running [*2] |-> !link_clk_out)
		else $error("link clock runs while pll stopped");
	force_legacy_a: assert property (pll_running |-> (port_bilingual & {port2_force_legacy, port1_force_legacy,
		port0_force_legacy}) == 3'h0) else $error("forced port went bilingual");
	peer_legacy_a: assert property ((peer_bilingual == 3'h0) [*5] |-> port_bilingual == 3'h0)
		else $error("bilingual without bilingual peer");
	idle_port_a: assert property (!(port_active[2] && port_connected[2]) [*5] |-> !cable_tx_en[2])
		else $error("idle port transmits");
	full_width_a: assert property (link_tx_ready && port_connected[0] && port_active[0] &&
		(link_iface_gen_select || link_tx_speed >= 3'h2) |-> ##1 cable_tx_en[0] [*8] ##1 !cable_tx_en[0])
		else $error("eight bit word length wrong");
	narrow_width_a: assert property (link_tx_ready && port_connected[0] && port_active[0] &&
		!link_iface_gen_select && link_tx_speed == 3'h0 |-> ##1 cable_tx_en[0] [*2] ##1 !cable_tx_en[0])
		else $error("two bit word length wrong");
	link_gap_a: assert property (seen && pll_running && link_clk_out != clk_q |->
		(link_iface_gen_select ? gap inside {4'h1, 4'h2} : gap inside {4'h2, 4'h3}))
		else $error("link clock rate wrong");

	cover property (link_tx_ready && link_iface_gen_select);
	cover property (link_tx_ready && !link_iface_gen_select && link_tx_speed == 3'h0);
	cover property ($fell(pll_running));
endmodule // sbp_link_datapath_checker

bind sbp_link_datapath sbp_link_datapath_checker chk (.*);

// ### bench/sbp_llc_model.sv
`timescale 1ns/1ps
module sbp_llc_model (
	input wire logic	aclk,
	input wire logic	link_tx_ready,
	input wire logic [7:0]	link_rx_data,
	input wire logic	link_rx_valid,
	input wire logic	stall,
	output logic [7:0]	link_tx_data,
	output logic		link_tx_valid,
	output logic [2:0]	link_tx_speed,
	output logic		link_rx_ready
);
	logic [7:0]	q[$];
	logic [7:0]	last = 8'h00;
	logic		got = 1'b0;
	initial begin
		link_tx_data = 8'h00;
		link_tx_valid = 1'b0;
		link_tx_speed = 3'h0;
		link_rx_ready = 1'b0;
	end

	////////////////////////////////////////////////////////////////
	// ready held up: a new word shows only as changed data
	always @(posedge aclk) begin
		link_rx_ready <= !stall;
		got <= link_rx_valid && link_rx_ready;
		last <= link_rx_data;
		if (link_rx_valid && link_rx_ready && (!got || link_rx_data !== last))
			q.push_back(link_rx_data);
	end

	task automatic send(input logic [7:0] d, input logic [2:0] s, output logic ok);
		int n;
		n = 0;
		@(posedge aclk);
		link_tx_data <= d;
		link_tx_speed <= s;
		link_tx_valid <= 1'b1;
		do begin
			@(negedge aclk);
			n++;
		end while (!link_tx_ready && n < 300);
		ok = link_tx_ready;
		@(posedge aclk);
		link_tx_valid <= 1'b0;
		link_tx_data <= ~d;
		repeat (12) @(posedge aclk);
	endtask
endmodule // sbp_llc_model

// ### bench/tb.sv
`timescale 1ns/1ps
module tb
	import sbp_pkg::*;
;
	logic		aclk = 1'b0;
	logic		aresetn = 1'b0;
	logic [7:0]	s_axi_awaddr = 8'h00;
	logic [7:0]	s_axi_araddr = 8'h00;
	logic [31:0]	s_axi_wdata = 32'h0;
	logic [3:0]	s_axi_wstrb = 4'hf;
	logic		s_axi_awvalid = 1'b0;
	logic		s_axi_wvalid = 1'b0;
	logic		s_axi_bready = 1'b0;
	logic		s_axi_arvalid = 1'b0;
	logic		s_axi_rready = 1'b0;
	logic		link_iface_gen_select = 1'b0;
	logic		power_down_pin = 1'b0;
	logic		stall = 1'b0;
	logic		port0_force_legacy = 1'b0;
	logic		port1_force_legacy = 1'b1;
	logic		port2_force_legacy = 1'b0;
	logic [2:0]	port_connected = 3'h7;
	logic [2:0]	port_active = 3'h3;
	logic [2:0]	peer_bilingual = 3'h3;
	logic [2:0]	cable_rx_bit = 3'h0;
	logic [2:0]	cable_rx_valid = 3'h0;
	logic [2:0]	cable_rx_speed = 3'h0;
	logic		s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, ok;
	logic		link_clk_out, link_tx_ready, link_tx_valid, link_rx_valid, link_rx_ready;
	logic		cable_rx_ready, boss_arb_enable, pll_running;
	logic [1:0]	s_axi_bresp, s_axi_rresp, r;
	logic [31:0]	s_axi_rdata, v;
	logic [7:0]	link_tx_data, link_rx_data, w8;
	logic [2:0]	link_tx_speed, cable_tx_bit, cable_tx_en, port_bilingual;
	logic [15:0]	cap = 16'h0;
	int		err_total = 0;
	int		n_compared = 0;
	int		mp = 0;
	int		ncap = 0;
	int		en2 = 0;
	int		n;

	sbp_link_datapath uut (.*);
	sbp_llc_model llc (.*);

	always #2.5 aclk = ~aclk;

	// serial capture of one port, newest bit at the top
	always @(posedge aclk) begin
		if (cable_tx_en[mp]) begin
			cap <= {cable_tx_bit[mp], cap[15:1]};
			ncap <= ncap + 1;
		end
		if (cable_tx_en[2])
			en2 <= en2 + 1;
	end

	////////////////////////////////////////////////////////////////
	function automatic int wid(input logic [2:0] s);
		return (link_iface_gen_select || s >= 3'h2) ? 8 : (s == 3'h1 ? 4 : 2);
	endfunction

	function automatic logic [31:0] m(input int w);
		return (32'h1 << w) - 32'h1;
	endfunction

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			err_total++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic stop_test();
		$display("compared %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task automatic rst();
		aresetn <= 1'b0;
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (10) @(posedge aclk);
	endtask

	////////////////////////////////////////////////////////////////
	// ready sampled at the falling edge, released after the next rising one
	task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
		logic aw, wr, b;
		b = 1'b0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!b) begin
			@(negedge aclk);
			aw = s_axi_awready;
			wr = s_axi_wready;
			b = s_axi_bvalid;
			r = s_axi_bresp;
			@(posedge aclk);
			if (aw) s_axi_awvalid <= 1'b0;
			if (wr) s_axi_wvalid <= 1'b0;
		end
		s_axi_bready <= 1'b0;
		chk("write response", {1'b1, e}, {b, r});
	endtask

	task automatic axr(input logic [7:0] a, output logic [31:0] d, input logic [1:0] e);
		logic t, rv;
		rv = 1'b0;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		while (!rv) begin
			@(negedge aclk);
			t = s_axi_arready;
			rv = s_axi_rvalid;
			d = s_axi_rdata;
			r = s_axi_rresp;
			@(posedge aclk);
			if (t) s_axi_arvalid <= 1'b0;
		end
		s_axi_rready <= 1'b0;
		chk("read response", {1'b1, e}, {rv, r});
	endtask

	////////////////////////////////////////////////////////////////
	task automatic tx(input logic [7:0] d, input logic [2:0] s);
		int c, w;
		c = ncap;
		w = wid(s);
		llc.send(d, s, ok);
		chk("tx ready", 1, ok);
		chk("tx bit count", w, ncap - c);
		chk("tx bits", d & m(w), 32'(cap >> (16 - w)));
	endtask

	// waits for the receiver's ready; a long low ready counts as refusal
	task automatic csend(input logic [7:0] d, input logic [2:0] s, output logic o);
		int k;
		k = 0;
		do begin
			@(negedge aclk);
			k++;
		end while (!cable_rx_ready && k < 40);
		o = cable_rx_ready;
		if (o) begin
			for (int i = 0; i < wid(s); i++) begin
				@(posedge aclk);
				cable_rx_speed <= s;
				cable_rx_valid <= 3'h1;
				cable_rx_bit <= {2'h0, d[i]};
			end
			@(posedge aclk);
			cable_rx_valid <= 3'h0;
			cable_rx_bit <= ~cable_rx_bit;
			repeat (6) @(posedge aclk);
		end
	endtask

	task automatic getw(output logic [7:0] o);
		int k;
		k = 0;
		while (llc.q.size() == 0 && k < 400) begin
			@(posedge aclk);
			k++;
		end
		o = llc.q.size() ? llc.q.pop_front() : 8'hxx;
	endtask

	task automatic rx(input logic [7:0] d, input logic [2:0] s);
		int c, w;
		c = ncap;
		w = wid(s);
		csend(d, s, ok);
		getw(w8);
		chk("rx word", d & m(w), w8);
		chk("repeat count", w, ncap - c);
		chk("repeat bits", d & m(w), 32'(cap >> (16 - w)));
	endtask

	////////////////////////////////////////////////////////////////
	initial begin
		#400000;
		err_total++;
		stop_test();
	end

	initial begin
		rst();
		axr(REG_CTRL, v, RESP_OKAY);
		chk("ctrl", CTRL_RESET, v);
		axr(REG_STATUS, v, RESP_OKAY);
		chk("status legacy", 32'h0000_008a, v);
		axw(REG_STATUS, 32'h0, RESP_OKAY);
		axw(8'h40, 32'h0, RESP_SLVERR);
		axr(8'h40, v, RESP_SLVERR);
		for (int s = 0; s < NUM_SPEEDS; s++)
			tx(8'h96 + 8'(s), 3'(s));
		axr(REG_PORT, v, RESP_OKAY);
		chk("port speeds", 32'h0000_0094, v);
		axr(REG_TX_RATE, v, RESP_OKAY);
		chk("tx rate", RATE_KBPS[NUM_SPEEDS-1], v);
		axr(REG_TX_CNT, v, RESP_OKAY);
		chk("tx count", NUM_SPEEDS, v);
		axw(REG_CTRL, 32'h6, RESP_OKAY);
		llc.send(8'h33, 3'h0, ok);
		chk("tx while disabled", 0, ok);
		axw(REG_CTRL, CTRL_RESET, RESP_OKAY);
		mp = 1;
		for (int s = 0; s < 3; s++)
			rx(8'hc5 - 8'(s), 3'(s));
		// link side stalls until the cable side is refused
		axw(REG_CTRL, 32'h3, RESP_OKAY);
		v = ncap;
		stall <= 1'b1;
		n = 0;
		ok = 1'b1;
		while (ok && n < 8) begin
			csend(8'h10 + 8'(n), 3'h2, ok);
			if (ok) n++;
		end
		chk("cable refused", 0, ok);
		chk("repeat off", v, ncap);
		axr(REG_STATUS, v, RESP_OKAY);
		chk("fifo level", FIFO_DEPTH, 32'(v[ST_LEVEL +: LVL_W]));
		stall <= 1'b0;
		for (int i = 0; i < n; i++) begin
			getw(w8);
			chk("drained word", 8'h10 + 8'(i), w8);
		end
		power_down_pin <= 1'b1;
		repeat (10) @(posedge aclk);
		axr(REG_STATUS, v, RESP_OKAY);
		chk("pll halted", 0, v[ST_PLL]);
		@(negedge aclk);
		chk("link clock held", 0, link_clk_out);
		@(posedge aclk);
		power_down_pin <= 1'b0;
		link_iface_gen_select <= 1'b1;
		peer_bilingual <= 3'h0;
		port2_force_legacy <= 1'b1;
		port_connected <= 3'h3;
		port_active <= 3'h7;
		rst();
		axr(REG_STATUS, v, RESP_OKAY);
		chk("status newer", 32'h0000_0187, v);
		mp = 0;
		tx(8'h5a, 3'h0);
		mp = 1;
		rx(8'ha3, 3'h0);
		chk("idle port silent", 0, en2);
		stop_test();
	end
endmodule // tb

// ### rtl/sbp_link_datapath.sv
// Decided for this implementation: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps

module sbp_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 4
) (
	input  wire logic                       aclk,
	input  wire logic                       aresetn,
	input  wire logic [WIDTH-1:0]           in_data,
	input  wire logic                       in_valid,
	output logic                            in_ready,
	output logic [WIDTH-1:0]                out_data,
	output logic                            out_valid,
	input  wire logic                       out_ready,
	output logic [$clog2(DEPTH+1)-1:0]      level
);
	localparam int PTR_W = $clog2(DEPTH);
	localparam int LVL_B = $clog2(DEPTH+1);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [PTR_W-1:0] wr_ptr;
	logic [PTR_W-1:0] rd_ptr;
	logic             push;
	logic             pop;

	assign in_ready  = (level != LVL_B'(DEPTH));
	assign out_valid = (level != '0);
	assign out_data  = mem[rd_ptr];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	always_ff @(posedge aclk) begin
		if (push)
			mem[wr_ptr] <= in_data;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			level  <= '0;
		end else begin
			if (push)
				wr_ptr <= (wr_ptr == PTR_W'(DEPTH-1)) ? '0 : wr_ptr + PTR_W'(1);
			if (pop)
				rd_ptr <= (rd_ptr == PTR_W'(DEPTH-1)) ? '0 : rd_ptr + PTR_W'(1);
			if (push && !pop)
				level <= level + LVL_B'(1);
			else if (pop && !push)
				level <= level - LVL_B'(1);
		end
	end
endmodule // sbp_fifo

module sbp_link_datapath
	import sbp_pkg::*;
(
	input  wire logic                  aclk,
	input  wire logic                  aresetn,
	input  wire logic [ADDR_W-1:0]     s_axi_awaddr,
	input  wire logic                  s_axi_awvalid,
	output logic                       s_axi_awready,
	input  wire logic [31:0]           s_axi_wdata,
	input  wire logic [3:0]            s_axi_wstrb,
	input  wire logic                  s_axi_wvalid,
	output logic                       s_axi_wready,
	output logic [1:0]                 s_axi_bresp,
	output logic                       s_axi_bvalid,
	input  wire logic                  s_axi_bready,
	input  wire logic [ADDR_W-1:0]     s_axi_araddr,
	input  wire logic                  s_axi_arvalid,
	output logic                       s_axi_arready,
	output logic [31:0]                s_axi_rdata,
	output logic [1:0]                 s_axi_rresp,
	output logic                       s_axi_rvalid,
	input  wire logic                  s_axi_rready,
	input  wire logic                  link_iface_gen_select,
	input  wire logic                  power_down_pin,
	input  wire logic                  port0_force_legacy,
	input  wire logic                  port1_force_legacy,
	input  wire logic                  port2_force_legacy,
	input  wire logic [NUM_PORTS-1:0]  port_connected,
	input  wire logic [NUM_PORTS-1:0]  port_active,
	input  wire logic [NUM_PORTS-1:0]  peer_bilingual,
	output logic                       link_clk_out,
	input  wire logic [WORD_W-1:0]     link_tx_data,
	input  wire logic                  link_tx_valid,
	input  wire logic [2:0]            link_tx_speed,
	output logic                       link_tx_ready,
	output logic [WORD_W-1:0]          link_rx_data,
	output logic                       link_rx_valid,
	input  wire logic                  link_rx_ready,
	input  wire logic [NUM_PORTS-1:0]  cable_rx_bit,
	input  wire logic [NUM_PORTS-1:0]  cable_rx_valid,
	input  wire logic [2:0]            cable_rx_speed,
	output logic                       cable_rx_ready,
	output logic [NUM_PORTS-1:0]       cable_tx_bit,
	output logic [NUM_PORTS-1:0]       cable_tx_en,
	output logic [NUM_PORTS-1:0]       port_bilingual,
	output logic                       boss_arb_enable,
	output logic                       pll_running
);

	////////////////////////////////////////////////////////////////////////////////
	// pin synchronisers
	logic [SYNC_W-1:0]    sync_a;
	logic [SYNC_W-1:0]    sync_b;
	logic                 gen2_pin_s;
	logic                 pd_s;
	logic [2:0]           force_s;
	logic [2:0]           conn_s;
	logic [2:0]           act_s;
	logic [2:0]           peer_s;
	logic                 tx_valid_s;
	logic [WORD_W-1:0]    tx_data_s;
	logic [2:0]           tx_speed_s;
	logic                 rx_ready_s;
	logic [2:0]           rx_bit_s;
	logic [2:0]           rx_valid_s;
	logic [2:0]           rx_speed_s;

	// multi-bit fields rely on the source holding them steady across the sample
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sync_a <= '0;
			sync_b <= '0;
		end else begin
			sync_a <= {link_iface_gen_select, power_down_pin, port2_force_legacy, port1_force_legacy,
			           port0_force_legacy, port_connected, port_active, peer_bilingual, link_tx_valid,
			           link_tx_data, link_tx_speed, link_rx_ready, cable_rx_bit, cable_rx_valid,
			           cable_rx_speed};
			sync_b <= sync_a;
		end
	end

	assign {gen2_pin_s, pd_s, force_s, conn_s, act_s, peer_s, tx_valid_s, tx_data_s, tx_speed_s,
	        rx_ready_s, rx_bit_s, rx_valid_s, rx_speed_s} = sync_b;

	////////////////////////////////////////////////////////////////////////////////
	// straps, caught once the synchronisers have settled after reset
	logic [1:0] strap_wait;
	logic       gen2;
	logic [2:0] force_cap;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			strap_wait <= '0;
			gen2       <= 1'b0;
			force_cap  <= '0;
		end else if (strap_wait != STRAP_SETTLE) begin
			strap_wait <= strap_wait + 2'h1;
			if (strap_wait == STRAP_SETTLE - 2'h1) begin
				gen2      <= gen2_pin_s;
				force_cap <= force_s;
			end
		end
	end

	// bilingual port signalling ignores the generation strap; boss arbitration follows it
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			port_bilingual  <= '0;
			boss_arb_enable <= 1'b0;
		end else begin
			port_bilingual  <= ~force_s & ~force_cap & peer_s & conn_s;
			boss_arb_enable <= gen2;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// pll model and link clock
	logic [NCO_W-1:0] nco_acc;
	logic [NCO_W:0]   nco_sum;
	logic             nco_edge;
	logic             link_tick;

	assign nco_sum   = {1'b0, nco_acc} + {1'b0, gen2 ? NCO_INC_GEN2 : NCO_INC_LEGACY};
	assign nco_edge  = pll_running && nco_sum[NCO_W];
	assign link_tick = nco_edge && !link_clk_out;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pll_running  <= 1'b0;
			nco_acc      <= '0;
			link_clk_out <= 1'b0;
		end else begin
			pll_running <= !pd_s && (strap_wait == STRAP_SETTLE);
			if (!pll_running) begin
				nco_acc      <= '0;
				link_clk_out <= 1'b0;
			end else begin
				nco_acc <= nco_sum[NCO_W-1:0];
				if (nco_edge)
					link_clk_out <= !link_clk_out;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// control register and counters
	logic [CTRL_W-1:0] ctrl;
	logic [31:0]       tx_count;
	logic [31:0]       rx_count;

	////////////////////////////////////////////////////////////////////////////////
	// receive: deserialise, buffer, deliver on link clock ticks
	logic               rx_any;
	logic [1:0]         rx_port;
	logic               rx_bit;
	logic [3:0]         rx_width;
	logic [3:0]         rx_cnt;
	logic [WORD_W-1:0]  rx_sh;
	logic               rx_pend;
	logic               next_rx_pend;
	logic               rx_take;
	logic               fifo_in_ready;
	logic [WORD_W-1:0]  fifo_out_data;
	logic               fifo_out_valid;
	logic               fifo_out_ready;
	logic [LVL_W-1:0]   fifo_level;

	always_comb begin
		rx_port = 2'h0;
		if (rx_valid_s[0])
			rx_port = 2'h0;
		else if (rx_valid_s[1])
			rx_port = 2'h1;
		else if (rx_valid_s[2])
			rx_port = 2'h2;
	end

	assign rx_any   = |rx_valid_s;
	assign rx_bit   = rx_bit_s[rx_port];
	assign rx_width = lane_width(rx_speed_s, gen2);
	assign rx_take  = rx_any && !rx_pend && pll_running && ctrl[CTRL_RX_EN];

	always_comb begin
		next_rx_pend = rx_pend;
		if (rx_pend && fifo_in_ready)
			next_rx_pend = 1'b0;
		else if (rx_take && rx_cnt == rx_width - 4'h1)
			next_rx_pend = 1'b1;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rx_cnt         <= '0;
			rx_sh          <= '0;
			rx_pend        <= 1'b0;
			cable_rx_ready <= 1'b0;
		end else begin
			rx_pend        <= next_rx_pend;
			cable_rx_ready <= !next_rx_pend && pll_running && ctrl[CTRL_RX_EN];
			if (rx_pend && fifo_in_ready)
				rx_sh <= '0;
			if (rx_take) begin
				rx_sh[rx_cnt[2:0]] <= rx_bit;
				rx_cnt             <= (rx_cnt == rx_width - 4'h1) ? 4'h0 : rx_cnt + 4'h1;
			end
		end
	end

	// stalling the link side really fills the fifo, then the cable side backs off
	sbp_fifo #(
		.WIDTH (WORD_W),
		.DEPTH (FIFO_DEPTH)
	) u_rx_fifo (
		.aclk      (aclk),
		.aresetn   (aresetn),
		.in_data   (rx_sh),
		.in_valid  (rx_pend),
		.in_ready  (fifo_in_ready),
		.out_data  (fifo_out_data),
		.out_valid (fifo_out_valid),
		.out_ready (fifo_out_ready),
		.level     (fifo_level)
	);

	assign fifo_out_ready = link_tick && (!link_rx_valid || rx_ready_s);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			link_rx_valid <= 1'b0;
			link_rx_data  <= '0;
			rx_count      <= '0;
		end else if (fifo_out_ready) begin
			link_rx_valid <= fifo_out_valid;
			link_rx_data  <= fifo_out_data;
			if (fifo_out_valid)
				rx_count <= rx_count + 32'h1;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// transmit: latch link word, serialise to cable ports
	logic [WORD_W-1:0] tx_sh;
	logic [3:0]        tx_left;
	logic              tx_wait_low;
	logic              tx_take;
	logic [2:0]        port_spd [NUM_PORTS];
	logic [2:0]        last_spd;

	// source must drop valid before the next word, since its valid lags by two flops
	assign tx_take = link_tick && tx_valid_s && !tx_wait_low && tx_left == 4'h0 && !rx_any
	                 && ctrl[CTRL_TX_EN];

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tx_sh         <= '0;
			tx_left       <= '0;
			tx_wait_low   <= 1'b0;
			link_tx_ready <= 1'b0;
			tx_count      <= '0;
			last_spd      <= SPD_S100;
			port_spd      <= '{default: SPD_S100};
		end else begin
			link_tx_ready <= tx_take;
			if (!tx_valid_s)
				tx_wait_low <= 1'b0;
			if (tx_take) begin
				tx_wait_low <= 1'b1;
				tx_sh       <= tx_data_s;
				tx_left     <= lane_width(tx_speed_s, gen2);
				last_spd    <= tx_speed_s;
				tx_count    <= tx_count + 32'h1;
				for (int p = 0; p < NUM_PORTS; p++)
					port_spd[p] <= port_speed(tx_speed_s, port_bilingual[p]);
			end else if (tx_left != 4'h0 && pll_running && !rx_any) begin
				tx_sh   <= tx_sh >> 1;
				tx_left <= tx_left - 4'h1;
			end
		end
	end

	// repeated traffic has priority; transmit waits while a packet passes through
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cable_tx_bit <= '0;
			cable_tx_en  <= '0;
		end else begin
			for (int p = 0; p < NUM_PORTS; p++) begin
				cable_tx_bit[p] <= 1'b0;
				cable_tx_en[p]  <= 1'b0;
				if (pll_running && conn_s[p] && act_s[p]) begin
					if (rx_any && ctrl[CTRL_RPT_EN] && rx_port != 2'(p)) begin
						cable_tx_bit[p] <= rx_bit;
						cable_tx_en[p]  <= 1'b1;
					end else if (!rx_any && tx_left != 4'h0) begin
						cable_tx_bit[p] <= tx_sh[0];
						cable_tx_en[p]  <= 1'b1;
					end
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// axi4-lite slave
	logic [ADDR_W-1:0] aw_addr;
	logic [31:0]       w_data;
	logic [3:0]        w_strb;
	logic [31:0]       rd_word;
	logic              rd_hit;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= RESP_OKAY;
			aw_addr       <= '0;
			w_data        <= '0;
			w_strb        <= '0;
			ctrl          <= CTRL_W'(CTRL_RESET);
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_addr       <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_data       <= s_axi_wdata;
				w_strb       <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (!s_axi_awready && !s_axi_wready && !s_axi_bvalid) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= RESP_OKAY;
				if (aw_addr == REG_CTRL) begin
					if (w_strb[0])
						ctrl <= w_data[CTRL_W-1:0];
				end else if (aw_addr != REG_STATUS && aw_addr != REG_PORT && aw_addr != REG_TX_CNT
				             && aw_addr != REG_RX_CNT && aw_addr != REG_TX_RATE)
					s_axi_bresp <= RESP_SLVERR;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid  <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
		end
	end

	always_comb begin
		rd_word = '0;
		rd_hit  = 1'b1;
		unique case (s_axi_araddr)
			REG_CTRL:    rd_word[CTRL_W-1:0] = ctrl;
			REG_STATUS: begin
				rd_word[ST_GEN2]               = gen2;
				rd_word[ST_PLL]                = pll_running;
				rd_word[ST_BOSS]               = boss_arb_enable;
				rd_word[ST_BIL +: NUM_PORTS]   = port_bilingual;
				rd_word[ST_FORCE +: NUM_PORTS] = force_cap;
				rd_word[ST_LEVEL +: LVL_W]     = fifo_level;
				rd_word[ST_TX_BUSY]            = (tx_left != 4'h0);
				rd_word[ST_RX_BUSY]            = rx_any;
			end
			REG_PORT:    rd_word[8:0] = {port_spd[2], port_spd[1], port_spd[0]};
			REG_TX_CNT:  rd_word = tx_count;
			REG_RX_CNT:  rd_word = rx_count;
			REG_TX_RATE: rd_word = RATE_KBPS[last_spd];
			default:     rd_hit  = 1'b0;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= '0;
			s_axi_rresp   <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rdata   <= rd_word;
			s_axi_rresp   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid  <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

endmodule // sbp_link_datapath

// ### rtl/sbp_pkg.sv
package sbp_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// clocks
	localparam int unsigned SYS_CLK_KHZ         = 200000;
	localparam int unsigned REF_OSC_KHZ         = 98304;
	localparam int unsigned LINK_CLK_LEGACY_KHZ = REF_OSC_KHZ / 2;
	localparam int unsigned LINK_CLK_GEN2_KHZ   = REF_OSC_KHZ;
	localparam int          NCO_W               = 32;
	// two pin edges per link clock period, so the accumulator counts edges
	localparam logic [NCO_W-1:0] NCO_INC_LEGACY =
		NCO_W'(((64'(LINK_CLK_LEGACY_KHZ) * 64'h2) << NCO_W) / 64'(SYS_CLK_KHZ));
	localparam logic [NCO_W-1:0] NCO_INC_GEN2   =
		NCO_W'(((64'(LINK_CLK_GEN2_KHZ) * 64'h2) << NCO_W) / 64'(SYS_CLK_KHZ));
	localparam logic [1:0] STRAP_SETTLE = 2'h3;

	////////////////////////////////////////////////////////////////////////////////
	// cable speeds
	typedef enum logic [2:0] {
		SPD_S100  = 3'h0,
		SPD_S200  = 3'h1,
		SPD_S400  = 3'h2,
		SPD_S400B = 3'h3,
		SPD_S800  = 3'h4
	} sbp_speed_e;
	localparam int unsigned NUM_SPEEDS = 5;
	localparam logic [31:0] RATE_KBPS [NUM_SPEEDS] = '{32'h0001_8000, 32'h0003_0000, 32'h0006_0000,
	                                                  32'h0007_8000, 32'h000f_0000};
	localparam logic [3:0] WIDTH_NARROW = 4'h2;
	localparam logic [3:0] WIDTH_MID    = 4'h4;
	localparam logic [3:0] WIDTH_FULL   = 4'h8;

	////////////////////////////////////////////////////////////////////////////////
	// datapath
	localparam int NUM_PORTS  = 3;
	localparam int WORD_W     = 8;
	localparam int FIFO_DEPTH = 4;
	localparam int LVL_W      = 3;
	localparam int SYNC_W     = 36;

	////////////////////////////////////////////////////////////////////////////////
	// register map
	localparam int          ADDR_W      = 8;
	localparam logic [7:0]  REG_CTRL    = 8'h00;
	localparam logic [7:0]  REG_STATUS  = 8'h04;
	localparam logic [7:0]  REG_PORT    = 8'h08;
	localparam logic [7:0]  REG_TX_CNT  = 8'h0c;
	localparam logic [7:0]  REG_RX_CNT  = 8'h10;
	localparam logic [7:0]  REG_TX_RATE = 8'h14;
	localparam logic [31:0] CTRL_RESET  = 32'h0000_0007;
	localparam int          CTRL_TX_EN  = 0;
	localparam int          CTRL_RX_EN  = 1;
	localparam int          CTRL_RPT_EN = 2;
	localparam int          CTRL_W      = 3;
	localparam int          ST_GEN2     = 0;
	localparam int          ST_PLL      = 1;
	localparam int          ST_BOSS     = 2;
	localparam int          ST_BIL      = 3;
	localparam int          ST_FORCE    = 6;
	localparam int          ST_LEVEL    = 9;
	localparam int          ST_TX_BUSY  = 12;
	localparam int          ST_RX_BUSY  = 13;
	localparam logic [1:0]  RESP_OKAY   = 2'h0;
	localparam logic [1:0]  RESP_SLVERR = 2'h2;

	////////////////////////////////////////////////////////////////////////////////
	function automatic logic [3:0] lane_width(input logic [2:0] spd, input logic gen2);
		if (gen2 || spd >= SPD_S400)
			return WIDTH_FULL;
		return (spd == SPD_S200) ? WIDTH_MID : WIDTH_NARROW;
	endfunction

	function automatic logic [2:0] port_speed(input logic [2:0] req, input logic bilingual);
		if (bilingual)
			return (req == SPD_S800) ? SPD_S800 : SPD_S400B;
		return (req > SPD_S400) ? SPD_S400 : req;
	endfunction

endpackage
